/* rtl/mcpc_top.v */
// Purpose: master compare pin control with APB registers and timer
// Assumes: APB3 slave, zero wait states, 32-bit data
// Notes:   timer counts once every TICK_DIV core clocks (bus cycle rate)
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "mcpc_consts.vh"

module mcpc_top #(
  parameter TICK_DIV = `MCPC_TICK_DIV
) (
  input  wire        CORE_CLK,     // Core clock, 100 MHz
  input  wire        RST_N,        // Synchronous reset, active low
  input  wire        PSEL,         // APB select
  input  wire        PENABLE,      // APB access phase
  input  wire        PWRITE,       // APB direction
  input  wire [31:0] PADDR,        // APB byte address
  input  wire [31:0] PWDATA,       // APB write data
  output reg  [31:0] PRDATA,       // APB read data
  output reg         PREADY,       // APB ready
  output reg         PSLVERR,      // APB error
  output reg  [7:3]  PIN_OUT,      // Timer output pin levels
  output reg  [7:3]  PIN_DRIVE_N,  // Output enable, low while driven
  output reg         MATCH_PULSE   // Master compare match strobe
);

  localparam [15:0] ADDR_MASK  = `MCPC_IDX_PIN_MASK  << 2;
  localparam [15:0] ADDR_LEVEL = `MCPC_IDX_PIN_LEVEL << 2;
  localparam [15:0] ADDR_CMP   = `MCPC_IDX_CMP_VALUE << 2;
  localparam [15:0] ADDR_ACT   = `MCPC_IDX_CH_ACTION << 2;
  localparam [15:0] ADDR_PCTL  = `MCPC_IDX_PULSE_CTL << 2;
  localparam [15:0] ADDR_STATE = `MCPC_IDX_PIN_STATE << 2;
  localparam [15:0] ADDR_CNT   = `MCPC_IDX_COUNTER   << 2;
  localparam [15:0] ADDR_CH2   = ADDR_CMP + 16'h0008;
  localparam [15:0] ADDR_CH3   = ADDR_CMP + 16'h0010;
  localparam [15:0] ADDR_CH4   = ADDR_CMP + 16'h0018;
  localparam [15:0] ADDR_CH5   = ADDR_CMP + 16'h0020;

  // Register state
  reg  [7:0]  compare_pin_mask;
  reg  [7:0]  compare_pin_level;
  reg  [15:0] master_cmp;
  reg  [15:0] ch_cmp [0:3];
  reg  [7:0]  ch_action;
  reg  [7:0]  pulse_acc_control;

  // Timer state
  reg  [15:0] timer_count;
  reg  [15:0] prescale;
  reg  [7:3]  pin_level;
  wire [15:0] tick_last;
  wire        tick;

  // Bus decode
  wire [15:0] addr;
  wire        addr_hi_zero;
  wire        setup_phase;
  wire        access_done;
  wire        hit_mask;
  wire        hit_level;
  wire        hit_cmp;
  wire        hit_ch2;
  wire        hit_ch3;
  wire        hit_ch4;
  wire        hit_ch5;
  wire        hit_act;
  wire        hit_pctl;
  wire [3:0]  hit_ch;
  reg         addr_ok;
  wire        wr_en;
  wire        rd_en;
  reg  [31:0] next_rdata;

  // Compare and pin logic
  wire        mst_match;
  wire [3:0]  ch_match;
  wire [7:3]  next_pin;
  wire [7:3]  mst_sel;
  integer     i;
  genvar      g;

  assign addr         = PADDR[15:0];
  assign addr_hi_zero = (PADDR[31:16] == 16'h0000);
  assign setup_phase  = PSEL & ~PENABLE;
  // Writes wait for the access phase so they land with PREADY
  assign access_done  = PSEL & PENABLE & PREADY;
  assign wr_en        = access_done & PWRITE & addr_ok;
  assign rd_en        = setup_phase & ~PWRITE;

  // One hit line per register keeps the write decode flat
  // Counter and pin state are read only: no hit line writes them
  assign hit_mask  = addr_hi_zero & (addr == ADDR_MASK);
  assign hit_level = addr_hi_zero & (addr == ADDR_LEVEL);
  assign hit_cmp   = addr_hi_zero & (addr == ADDR_CMP);
  assign hit_ch2   = addr_hi_zero & (addr == ADDR_CH2);
  assign hit_ch3   = addr_hi_zero & (addr == ADDR_CH3);
  assign hit_ch4   = addr_hi_zero & (addr == ADDR_CH4);
  assign hit_ch5   = addr_hi_zero & (addr == ADDR_CH5);
  assign hit_act   = addr_hi_zero & (addr == ADDR_ACT);
  assign hit_pctl  = addr_hi_zero & (addr == ADDR_PCTL);
  assign hit_ch    = {hit_ch5, hit_ch4, hit_ch3, hit_ch2};

  // Prescaler end value; a TICK_DIV of one ticks on every clock
  assign tick_last = TICK_DIV[15:0] - 16'h0001;
  assign tick      = (prescale == tick_last);

  // Compare is evaluated against the count that is live this tick
  assign mst_match = tick && (master_cmp == timer_count);

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      assign ch_match[g] = tick && (ch_cmp[g] == timer_count);
    end
  endgenerate

  // Pin 7 has no other channel; it joins only when set as output
  assign mst_sel[7]   = compare_pin_mask[7] &
                        pulse_acc_control[`MCPC_PIN7_DIR_BIT];
  assign mst_sel[6:3] = compare_pin_mask[6:3];

  mcpc_pin_action u_pin7 (
    .cur_level  (pin_level[7]),
    .ch_match   (1'b0),
    .ch_action  (`MCPC_ACT_NONE),
    .mst_match  (mst_match),
    .mst_sel    (mst_sel[7]),
    .mst_level  (compare_pin_level[7]),
    .next_level (next_pin[7])
  );

  // Channel 2 drives pin 6 down to channel 5 on pin 3
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
      mcpc_pin_action u_pin (
        .cur_level  (pin_level[6-g]),
        .ch_match   (ch_match[g]),
        .ch_action  (ch_action[7-2*g -: 2]),
        .mst_match  (mst_match),
        .mst_sel    (mst_sel[6-g]),
        .mst_level  (compare_pin_level[6-g]),
        .next_level (next_pin[6-g])
      );
    end
  endgenerate

  always @* begin
    addr_ok = addr_hi_zero;
    case (addr)
      ADDR_MASK, ADDR_LEVEL, ADDR_CMP, ADDR_ACT, ADDR_PCTL,
      ADDR_STATE, ADDR_CNT, ADDR_CH2, ADDR_CH3, ADDR_CH4,
      ADDR_CH5: addr_ok = addr_hi_zero;
      default:  addr_ok = 1'b0;
    endcase
  end

  always @* begin
    next_rdata = 32'h00000000;
    if (addr_hi_zero) begin
      case (addr)
        ADDR_MASK:  next_rdata = {24'h000000,
                                  compare_pin_mask & `MCPC_LOW_BITS_MASK};
        ADDR_LEVEL: next_rdata = {24'h000000,
                                  compare_pin_level & `MCPC_LOW_BITS_MASK};
        ADDR_CMP:   next_rdata = {16'h0000, master_cmp};
        ADDR_CH2:   next_rdata = {16'h0000, ch_cmp[0]};
        ADDR_CH3:   next_rdata = {16'h0000, ch_cmp[1]};
        ADDR_CH4:   next_rdata = {16'h0000, ch_cmp[2]};
        ADDR_CH5:   next_rdata = {16'h0000, ch_cmp[3]};
        ADDR_ACT:   next_rdata = {24'h000000, ch_action};
        ADDR_PCTL:  next_rdata = {24'h000000, pulse_acc_control};
        ADDR_STATE: next_rdata = {24'h000000, pin_level, 3'b000};
        ADDR_CNT:   next_rdata = {16'h0000, timer_count};
        default:    next_rdata = 32'h00000000;
      endcase
    end
  end

  // Prescaler sets the timer rate, one tick per bus cycle
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      prescale <= 16'h0000;
    end else if (tick) begin
      prescale <= 16'h0000;
    end else begin
      prescale <= prescale + 16'h0001;
    end
  end

  // Timer runs free from reset and wraps at the top
  // A wrap lets a compare set behind the count fire on the next lap
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      timer_count <= 16'h0000;
    end else if (tick) begin
      timer_count <= timer_count + 16'h0001;
    end
  end

  // Low bits are not stored, so they can never read back as one
  // Clearing a mask bit releases the pin from the master at once
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      compare_pin_mask <= `MCPC_PIN_MASK_RST;
    end else if (wr_en && hit_mask) begin
      compare_pin_mask <= PWDATA[7:0] & `MCPC_LOW_BITS_MASK;
    end
  end

  // Level bits under a clear mask bit are stored but do nothing
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      compare_pin_level <= `MCPC_PIN_LEVEL_RST;
    end else if (wr_en && hit_level) begin
      compare_pin_level <= PWDATA[7:0] & `MCPC_LOW_BITS_MASK;
    end
  end

  // Compare values reset to the far end of the count
  // A write lands on the access edge and acts from the next tick
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      master_cmp <= `MCPC_CMP_VALUE_RST;
    end else if (wr_en && hit_cmp) begin
      master_cmp <= PWDATA[15:0];
    end
  end

  // Channel compares sit at eight-byte steps after the master
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      for (i = 0; i < 4; i = i + 1) begin
        ch_cmp[i] <= `MCPC_CMP_VALUE_RST;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_en && hit_ch[i]) begin
          ch_cmp[i] <= PWDATA[15:0];
        end
      end
    end
  end

  // Two bits per channel, channel 2 in the top pair
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ch_action <= `MCPC_CH_ACTION_RST;
    end else if (wr_en && hit_act) begin
      ch_action <= PWDATA[7:0];
    end
  end

  // Only the pin 7 direction bit acts here; the rest is storage
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pulse_acc_control <= `MCPC_PULSE_CTL_RST;
    end else if (wr_en && hit_pctl) begin
      pulse_acc_control <= PWDATA[7:0];
    end
  end

  // Every access gets exactly one access phase, no wait states
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup_phase;
    end
  end

  // Unmapped or high addresses are refused rather than aliased
  // Refused writes change nothing
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= setup_phase & ~addr_ok;
    end
  end

  // Read data is taken at setup and stands until the next read
  // Reads have no side effects, so the early capture is safe
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
    end else if (rd_en) begin
      PRDATA <= next_rdata;
    end
  end

  // Pin level moves only on a timer tick, so edges hit exact counts
  // Kept apart from PIN_OUT so the state read sees the same level
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pin_level <= 5'b00000;
    end else begin
      pin_level <= next_pin;
    end
  end

  // Output copy keeps the pins straight off a flip-flop
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PIN_OUT <= 5'b00000;
    end else begin
      PIN_OUT <= next_pin;
    end
  end

  // Pin 7 is an input until its direction bit is set
  // Pins 6..3 have no direction control and drive at all times outside reset
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PIN_DRIVE_N <= 5'b11111;
    end else begin
      PIN_DRIVE_N[7]   <= ~pulse_acc_control[`MCPC_PIN7_DIR_BIT];
      PIN_DRIVE_N[6:3] <= 4'b0000;
    end
  end

  // Strobe marks the count on which the master compare fired
  // Software may poll it instead of reading the counter
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      MATCH_PULSE <= 1'b0;
    end else begin
      MATCH_PULSE <= mst_match;
    end
  end

endmodule // mcpc_top

/* rtl/mcpc_consts.vh */
// Purpose: shared constants of the master compare pin control block
// Assumes: APB byte addresses, 32-bit data, 100 MHz core clock
// Notes:   definitions only
`ifndef MCPC_CONSTS_VH
`define MCPC_CONSTS_VH

// Printed offsets are not multiples of four: kept as indices
`define MCPC_IDX_PIN_MASK    16'h100c
`define MCPC_IDX_PIN_LEVEL   16'h100d
`define MCPC_IDX_CMP_VALUE   16'h1016
`define MCPC_IDX_CH_ACTION   16'h1020
`define MCPC_IDX_PULSE_CTL   16'h1026
`define MCPC_IDX_PIN_STATE   16'h1000
`define MCPC_IDX_COUNTER     16'h100e

`define MCPC_PIN_MASK_RST    8'h00
`define MCPC_PIN_LEVEL_RST   8'h00
`define MCPC_CMP_VALUE_RST   16'hffff
`define MCPC_CH_ACTION_RST   8'h00
`define MCPC_PULSE_CTL_RST   8'h00
`define MCPC_LOW_BITS_MASK   8'hf8
`define MCPC_PIN7_DIR_BIT    7

`define MCPC_ACT_NONE        2'b00
`define MCPC_ACT_TOGGLE      2'b01
`define MCPC_ACT_LOW         2'b10
`define MCPC_ACT_HIGH        2'b11

`define MCPC_TICK_DIV        50

`endif

/* rtl/mcpc_pin_action.v */
// Purpose: next level of one timer output pin for one timer count
// Assumes: match strobes are one-cycle, in the core clock domain
// Notes:   master compare is applied last, so it wins a same-count clash
`timescale 1ns/1ps
`include "mcpc_consts.vh"

module mcpc_pin_action (
  input  wire       cur_level,   // Present pin level
  input  wire       ch_match,    // Other channel match this count
  input  wire [1:0] ch_action,   // Other channel action code
  input  wire       mst_match,   // Master compare match this count
  input  wire       mst_sel,     // Pin selected by mask
  input  wire       mst_level,   // Level from level register
  output reg        next_level   // Resulting pin level
);

  always @* begin
    next_level = cur_level;
    if (ch_match) begin
      case (ch_action)
        `MCPC_ACT_TOGGLE: next_level = ~cur_level;
        `MCPC_ACT_LOW:    next_level = 1'b0;
        `MCPC_ACT_HIGH:   next_level = 1'b1;
        default:          next_level = cur_level;
      endcase
    end
    if (mst_match && mst_sel) begin
      next_level = mst_level;
    end
  end

endmodule // mcpc_pin_action

/* bench/mcpc_pin_load.sv */
// Purpose: loads on the timer output pins
// Assumes: a pull-up on every pin
// Notes: an undriven pin shows the pull-up level
`timescale 1ns/1ps
module mcpc_pin_load (
  input  wire [7:3] pin_out,     // Block levels
  input  wire [7:3] pin_drive_n, // Low while driven
  output wire [7:3] pad          // Level at the load
);
  assign pad = (pin_out & ~pin_drive_n) | pin_drive_n;
endmodule // mcpc_pin_load

/* bench/mcpc_top_asserts.sv */
// Purpose: port checks of the master compare pin block
// Assumes: TICK_DIV of at least 2
// Notes: bound to the top module
`timescale 1ns/1ps
module mcpc_top_asserts #(parameter TICK_DIV = 50) (
  input wire        CORE_CLK, RST_N, PSEL, PENABLE, PWRITE,
  input wire [31:0] PADDR, PWDATA, PRDATA,
  input wire        PREADY, PSLVERR, MATCH_PULSE,
  input wire [7:3]  PIN_OUT, PIN_DRIVE_N
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  property p_err; PSLVERR |-> PREADY; endproperty
  property p_unmap;
    PSEL && !PENABLE && !PWRITE && PADDR == 32'h4004
      |=> PSLVERR && PRDATA == 32'h0;
  endproperty
  property p_low;
    PREADY && !PWRITE && (PADDR == 32'h4030 || PADDR == 32'h4034)
      |-> (PRDATA & 32'hffffff07) == 32'h0;
  endproperty
  property p_drv; $past(RST_N) |-> PIN_DRIVE_N[6:3] == 4'h0; endproperty
  property p_pulse; MATCH_PULSE |=> !MATCH_PULSE; endproperty
  property p_step; $changed(PIN_OUT) && $past(RST_N) |=> $stable(PIN_OUT);
  endproperty
  property p_pin7; $changed(PIN_OUT[7]) |-> !PIN_DRIVE_N[7]; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  a_err: assert property (p_err) else $error("error without ready");
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  a_low: assert property (p_low) else $error("unused bits set");
  a_drv: assert property (p_drv) else $error("pins 6..3 undriven");
  a_pulse: assert property (p_pulse) else $error("long match");
  a_step: assert property (p_step) else $error("pin step short");
  a_pin7: assert property (p_pin7) else $error("pin 7 undriven");
  c_match: cover property (MATCH_PULSE);
  c_err: cover property (PSLVERR);
  c_pin7: cover property ($rose(PIN_OUT[7]));
endmodule // mcpc_top_asserts
bind mcpc_top mcpc_top_asserts #(.TICK_DIV(TICK_DIV)) u_mcpc_top_asserts (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MATCH_PULSE(MATCH_PULSE),
  .PIN_OUT(PIN_OUT), .PIN_DRIVE_N(PIN_DRIVE_N));

/* bench/tb_mcpc_top.sv */
// Purpose: register and pin tests of the master compare block
// Assumes: TICK_DIV of 2, APB byte addresses
// Notes: pin 7 is read back through the load model
`timescale 1ns/1ps
module tb_mcpc_top;
  localparam TD = 2;
  logic        clk, rst_n, psel, pen, pwr, err;
  logic [31:0] paddr, pwdata, r, c;
  wire  [31:0] prdata;
  wire         pready, pslverr, mp;
  wire  [7:3]  pout, pdn, pad;
  int          bad_count, checked, hi;
  mcpc_top #(.TICK_DIV(TD)) u_mcpc_top (.CORE_CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PIN_OUT(pout), .PIN_DRIVE_N(pdn), .MATCH_PULSE(mp));
  mcpc_pin_load u_mcpc_pin_load (.pin_out(pout), .pin_drive_n(pdn),
    .pad(pad));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Master fires k counts after the counter read
  task arm(input int k);
    xfer(0, 32'h4038, 0);
    xfer(1, 32'h4058, (r + k) & 32'hffff);
  endtask
  task waitm;
    int n;
    n = 0;
    while (mp !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 200), 1);
  endtask
  // Channel 2 at c+10, master d counts later
  task pair(input int d);
    xfer(0, 32'h4038, 0);
    c = r;
    xfer(1, 32'h4060, (c + 10) & 32'hffff);
    xfer(1, 32'h4058, (c + 10 + d) & 32'hffff);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    bad_count++;
    conclude;
  end
  initial begin
    rst_n = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0;
    bad_count = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(pdn), 32'h10);
    chk(32'(pout), 0);
    for (int a = 32'h4030; a <= 32'h4034; a += 4) begin
      xfer(0, a, 0);
      chk(r, 0);
      xfer(1, a, 32'hffffffff);
      xfer(0, a, 0);
      chk(r, 32'hf8);
    end
    xfer(0, 32'h4004, 0);
    chk({r[31:1], err}, 1);
    $display("registers done");
    xfer(1, 32'h4030, 32'h30);
    xfer(1, 32'h4034, 32'h20);
    arm(8);
    waitm;
    chk(32'(pout), 32'h04);
    xfer(1, 32'h4034, 32'h18);
    arm(8);
    waitm;
    chk(32'(pout), 32'h02);
    xfer(1, 32'h4030, 32'h80);
    xfer(1, 32'h4034, 32'h80);
    arm(8);
    waitm;
    chk({pout, pad[7]}, 12'h5);
    xfer(1, 32'h4098, 32'h80);
    arm(8);
    waitm;
    chk({pout, pdn}, 10'h240);
    $display("master pins done");
    xfer(1, 32'h4030, 0);
    for (int k = 3; k >= 0; k--) begin
      xfer(1, 32'h4080, 32'(k) << 6);
      xfer(0, 32'h4038, 0);
      xfer(1, 32'h4060, (r + 8) & 32'hffff);
      repeat (40) @(posedge clk);
      chk(pout[6], 4'b1011 >> k & 1);
    end
    xfer(1, 32'h4030, 32'h40);
    xfer(1, 32'h4034, 0);
    xfer(1, 32'h4080, 32'hc0);
    pair(0);
    waitm;
    chk(pout[6], 0);
    pair(1);
    hi = 0;
    repeat (60) begin
      @(posedge clk);
      hi += pout[6];
    end
    chk(hi, TD);
    $display("shared pin done");
    conclude;
  end
endmodule // tb_mcpc_top
